// file: hdl/rtcwt_defs.svh
// constants of the wakeup countdown timer: offsets, fields, resets, timing
//******************************************************************************
// Overview of operation
// - enable low, counter reads return the preset
// - enable cleared halts timer, interrupt stays low
// - enable rising restarts count from preset
// - expiry sets flag, held until software clears
// - writing 0 clears flag, interrupt stays low
// - writing 1 to flag does nothing
// - interrupt enabled, expiry pulls interrupt low
// - interrupt disabled, expiry leaves output released
// - clearing interrupt enable releases low output
// - backup gating selects supply modes that count
// - stop bit cleared resumes from frozen value
// - backup gating on makes stop bit ignored
// - global stop halts slow source countdowns
// - enable low means no counting at all
// - count begins at acknowledge clock rising edge
// - interval is preset times source period
// - three-bit select picks one of five sources
// - expiry reloads preset and repeats periodically
// - interrupt auto-releases after release time
//******************************************************************************
`ifndef RTCWT_DEFS_SVH
`define RTCWT_DEFS_SVH

// register offsets
`define RTCWT_ADDR_CNT_LO   8'h1a
`define RTCWT_ADDR_CNT_HI   8'h1b
`define RTCWT_ADDR_EXT      8'h1c
`define RTCWT_ADDR_FLAG     8'h1d
`define RTCWT_ADDR_CTRL     8'h1e

// field positions
`define RTCWT_EXT_TE_BIT    4
`define RTCWT_FLAG_TF_BIT   4
`define RTCWT_CTRL_STOP_BIT 6
`define RTCWT_CTRL_TIE_BIT  4
`define RTCWT_CTRL_TIMER_STOP_BIT_BIT 2
`define RTCWT_CTRL_BKON_BIT 1
`define RTCWT_CTRL_BKE_BIT  0

// source select codes
`define RTCWT_SRC_4096HZ    3'h0
`define RTCWT_SRC_64HZ      3'h1
`define RTCWT_SRC_1HZ       3'h2
`define RTCWT_SRC_MIN       3'h3
`define RTCWT_SRC_HOUR      3'h4

// reset values
`define RTCWT_PRESET_RST    16'h0000
`define RTCWT_SEL_RST       3'h0

// divider chain
`define RTCWT_CLK_HZ        25000000
`define RTCWT_BASE_HZ       4096
`define RTCWT_DIV64_LAST    6'h3f
`define RTCWT_DIV60_LAST    6'h3b

// timing, in ns, and the derived least cycle counts (rounded up)
`define RTCWT_CLK_NS        40
`define RTCWT_RTN_FAST_NS   122000
`define RTCWT_RTN_SLOW_NS   7570000
`define RTCWT_RTN_FAST_CYC  ((`RTCWT_RTN_FAST_NS + `RTCWT_CLK_NS - 1) / `RTCWT_CLK_NS)
`define RTCWT_RTN_SLOW_CYC  ((`RTCWT_RTN_SLOW_NS + `RTCWT_CLK_NS - 1) / `RTCWT_CLK_NS)

`endif

// file: hdl/rtcwt_pkg.sv
// types shared by the wakeup countdown timer
package rtcwt_pkg;

    // countdown run state
    typedef enum logic [1:0]
    {
        RUN_IDLE,
        RUN_ARMED,
        RUN_COUNT
    } rtcwt_run_t;

endpackage : rtcwt_pkg

// file: hdl/rtcwt_sync.sv
// two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none

module rtcwt_sync
#(
    parameter int WIDTH = 1
)
(
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta; // first stage, read only by the second

    // two stages; the first feeds nothing but the second
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta   <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule : rtcwt_sync

`default_nettype wire

// file: hdl/rtcwt_prescaler.sv
// divider chain producing the five countdown source ticks
`timescale 1ns/1ps
`default_nettype none
`include "rtcwt_defs.svh"

module rtcwt_prescaler
#(
    parameter int CLK_HZ  = `RTCWT_CLK_HZ,
    parameter int BASE_HZ = `RTCWT_BASE_HZ
)
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    // global stop, freezes the 64 Hz and slower stages
    input  wire logic       i_stop,
    // one-cycle ticks: [0] 4096 Hz, [1] 64 Hz, [2] 1 Hz, [3] 1/60 Hz, [4] 1/3600 Hz
    output logic [4:0]      o_tick
);

    // next value of a wrapping stage counter
    function automatic logic [5:0] stage_next(input logic [5:0] c, input logic [5:0] last);
        stage_next = (c == last) ? 6'h00 : 6'(c + 6'h01);
    endfunction : stage_next

    logic [31:0] acc;      // fractional phase, avoids drift since clock is not a multiple
    logic [5:0]  c64;      // 4096 Hz -> 64 Hz
    logic [5:0]  c1;       // 64 Hz -> 1 Hz
    logic [5:0]  cmin;     // 1 Hz -> per minute
    logic [5:0]  chour;    // per minute -> per hour

    wire  [31:0] acc_sum  = acc + 32'(BASE_HZ);
    wire         t4k      = (acc_sum >= 32'(CLK_HZ));
    wire         t64      = t4k && !i_stop && (c64 == `RTCWT_DIV64_LAST);
    wire         t1       = t64 && (c1 == `RTCWT_DIV64_LAST);
    wire         tmin     = t1 && (cmin == `RTCWT_DIV60_LAST);
    wire         thour    = tmin && (chour == `RTCWT_DIV60_LAST);

    assign o_tick = {thour, tmin, t1, t64, t4k};

    // phase accumulator, base tick on each overflow
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            acc <= 32'h0000_0000;
        else
            acc <= t4k ? 32'(acc_sum - 32'(CLK_HZ)) : acc_sum;
    end

    // slower stages; held while stopped
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            c64   <= 6'h00;
            c1    <= 6'h00;
            cmin  <= 6'h00;
            chour <= 6'h00;
        end
        else if (t4k && !i_stop)
        begin
            c64 <= stage_next(c64, `RTCWT_DIV64_LAST);
            if (t64)
                c1 <= stage_next(c1, `RTCWT_DIV64_LAST);
            if (t1)
                cmin <= stage_next(cmin, `RTCWT_DIV60_LAST);
            if (tmin)
                chour <= stage_next(chour, `RTCWT_DIV60_LAST);
        end
    end

endmodule : rtcwt_prescaler

`default_nettype wire

// file: hdl/rtcwt_top.sv
// wakeup countdown timer of the real-time clock, with its register port
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rtcwt_defs.svh"

module rtcwt_top
    import rtcwt_pkg::*;
#(
    parameter int          CLK_HZ       = `RTCWT_CLK_HZ,
    parameter logic [17:0] RTN_SLOW_CYC = 18'(`RTCWT_RTN_SLOW_CYC),
    parameter logic [17:0] RTN_FAST_CYC = 18'(`RTCWT_RTN_FAST_CYC)
)
(
    // clock and reset
    input  wire logic       I_CLK,
    input  wire logic       I_NRST,
    // register port
    input  wire logic [7:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic [7:0]      O_RDATA,
    // serial bus clock pin, used only to time the start
    input  wire logic       I_SCL,
    // supply mode pin: 1 while on backup battery
    input  wire logic       I_VBAT_MODE,
    // open-drain interrupt pin
    output logic            O_IRQ_O,
    output logic            O_IRQ_OE
);

    //**************************************************************************
    // register state
    //**************************************************************************

    logic [15:0] preset;              // programmed reload value
    logic [2:0]  source_sel;          // countdown source select
    logic        timer_enable_bit;    // countdown enable
    logic        timer_expiry_flag;   // sticky expiry flag
    logic        global_stop;         // global clock stop
    logic        timer_irq_enable;    // interrupt enable
    logic        timer_stop_bit;      // local freeze
    logic        backup_select_bit;   // which supply counts when gated
    logic        backup_gating_enable;// supply gating on

    //**************************************************************************
    // countdown and interrupt state
    //**************************************************************************

    rtcwt_run_t  run_state;           // idle, waiting for ack clock, counting
    rtcwt_run_t  next_run_state;
    logic [15:0] count;               // running count
    logic        irq_low;             // interrupt pin pulled low
    logic [17:0] rtn_cnt;             // cycles left before auto release
    logic        scl_q;               // previous synchronised clock level

    //**************************************************************************
    // synchronised pins and source ticks
    //**************************************************************************

    logic [1:0]  pin_sync;            // {inverted scl, vbat} after two flops
    logic [4:0]  tick;                // one pulse per source period

    rtcwt_sync #(.WIDTH(2)) u_sync
    (
        .i_clk   (I_CLK),
        .i_nrst  (I_NRST),
        .i_async ({~I_SCL, I_VBAT_MODE}),
        .o_sync  (pin_sync)
    );

    rtcwt_prescaler #(.CLK_HZ(CLK_HZ), .BASE_HZ(`RTCWT_BASE_HZ)) u_prescaler
    (
        .i_clk   (I_CLK),
        .i_nrst  (I_NRST),
        .i_stop  (global_stop),
        .o_tick  (tick)
    );

    // scl travels inverted so the zero reset of the synchroniser equals the
    // idle-high line; otherwise a false rise right after reset could start an armed count
    wire scl_s   = !pin_sync[1];
    wire vbat_s  = pin_sync[0];
    wire scl_ris = scl_s && !scl_q;

    //**************************************************************************
    // write decode
    //**************************************************************************

    wire wr_lo   = I_WR && (I_ADDR == `RTCWT_ADDR_CNT_LO);
    wire wr_hi   = I_WR && (I_ADDR == `RTCWT_ADDR_CNT_HI);
    wire wr_ext  = I_WR && (I_ADDR == `RTCWT_ADDR_EXT);
    wire wr_flag = I_WR && (I_ADDR == `RTCWT_ADDR_FLAG);
    wire wr_ctrl = I_WR && (I_ADDR == `RTCWT_ADDR_CTRL);

    wire te_new  = I_WDATA[`RTCWT_EXT_TE_BIT];
    wire te_rise = wr_ext && te_new && !timer_enable_bit;
    wire te_fall = wr_ext && !te_new;
    wire tie_clr = wr_ctrl && !I_WDATA[`RTCWT_CTRL_TIE_BIT];
    // only a written 0 clears; a written 1 leaves the flag alone
    wire tf_clr  = wr_flag && !I_WDATA[`RTCWT_FLAG_TF_BIT];

    //**************************************************************************
    // countdown gating
    //**************************************************************************

    // selected source tick; undefined codes never tick
    wire src_tick = (source_sel == `RTCWT_SRC_4096HZ) ? tick[0] :
                    (source_sel == `RTCWT_SRC_64HZ)   ? tick[1] :
                    (source_sel == `RTCWT_SRC_1HZ)    ? tick[2] :
                    (source_sel == `RTCWT_SRC_MIN)    ? tick[3] :
                    (source_sel == `RTCWT_SRC_HOUR)   ? tick[4] : 1'b0;

    wire supply_ok = !backup_gating_enable || (backup_select_bit == vbat_s);
    wire local_ok  = backup_gating_enable || !timer_stop_bit;
    wire gstop_ok  = !global_stop || (source_sel == `RTCWT_SRC_4096HZ);
    wire count_on  = (run_state == RUN_COUNT) && timer_enable_bit
                     && supply_ok && local_ok && gstop_ok;
    wire step      = count_on && src_tick;
    // a zero preset is not valid; it behaves as one so the timer cannot lock up
    wire expiry    = step && (count <= 16'h0001);

    // release time depends on the source in use
    wire [17:0] rtn_load = (source_sel == `RTCWT_SRC_4096HZ) ? RTN_FAST_CYC
                                                             : RTN_SLOW_CYC;

    //**************************************************************************
    // run state
    //**************************************************************************

    // wait for the ack clock after enabling, then count until disabled
    always_comb
    begin
        next_run_state = run_state;
        case (run_state)
            RUN_IDLE:
            begin
                if (te_rise)
                    next_run_state = RUN_ARMED;
            end
            RUN_ARMED:
            begin
                if (te_fall)
                    next_run_state = RUN_IDLE;
                else if (scl_ris)
                    next_run_state = RUN_COUNT;
            end
            RUN_COUNT:
            begin
                if (te_fall)
                    next_run_state = RUN_IDLE;
            end
            default:
                next_run_state = RUN_IDLE;
        endcase
    end

    // state register and clock edge history
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            run_state <= RUN_IDLE;
            scl_q     <= 1'b1;
        end
        else
        begin
            run_state <= next_run_state;
            scl_q     <= scl_s;
        end
    end

    //**************************************************************************
    // configuration registers
    //**************************************************************************

    // preset bytes; the host is expected to clear enable first
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            preset <= `RTCWT_PRESET_RST;
        else if (wr_lo)
            preset[7:0] <= I_WDATA;
        else if (wr_hi)
            preset[15:8] <= I_WDATA;
    end

    // extension and control bits
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            source_sel           <= `RTCWT_SEL_RST;
            timer_enable_bit     <= 1'b0;
            global_stop          <= 1'b0;
            timer_irq_enable     <= 1'b0;
            timer_stop_bit       <= 1'b0;
            backup_select_bit    <= 1'b0;
            backup_gating_enable <= 1'b0;
        end
        else
        begin
            if (wr_ext)
            begin
                source_sel       <= I_WDATA[2:0];
                timer_enable_bit <= te_new;
            end
            if (wr_ctrl)
            begin
                global_stop          <= I_WDATA[`RTCWT_CTRL_STOP_BIT];
                timer_irq_enable     <= I_WDATA[`RTCWT_CTRL_TIE_BIT];
                timer_stop_bit       <= I_WDATA[`RTCWT_CTRL_TIMER_STOP_BIT_BIT];
                backup_select_bit    <= I_WDATA[`RTCWT_CTRL_BKON_BIT];
                backup_gating_enable <= I_WDATA[`RTCWT_CTRL_BKE_BIT];
            end
        end
    end

    //**************************************************************************
    // countdown
    //**************************************************************************

    // load on enable, step on source tick, reload on expiry; frozen otherwise
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            count <= `RTCWT_PRESET_RST;
        else if (te_rise)
            count <= preset;
        else if (expiry)
            count <= preset;
        else if (step)
            count <= 16'(count - 16'h0001);
    end

    //**************************************************************************
    // expiry flag
    //**************************************************************************

    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            timer_expiry_flag <= 1'b0;
        else if (expiry)
            timer_expiry_flag <= 1'b1;
        else if (tf_clr)
            timer_expiry_flag <= 1'b0;
    end

    //**************************************************************************
    // interrupt pin
    //**************************************************************************

    // low on enabled expiry; released by timeout or by clearing the enable.
    // clearing the timer enable or the flag alone leaves the pin as it is
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            irq_low <= 1'b0;
            rtn_cnt <= 18'h00000;
        end
        else if (tie_clr)
        begin
            irq_low <= 1'b0;
            rtn_cnt <= 18'h00000;
        end
        else if (expiry && timer_irq_enable)
        begin
            irq_low <= 1'b1;
            rtn_cnt <= rtn_load;
        end
        else if (irq_low)
        begin
            rtn_cnt <= 18'(rtn_cnt - 18'h00001);
            if (rtn_cnt <= 18'h00001)
                irq_low <= 1'b0;
        end
    end

    // open drain: only ever drives low
    assign O_IRQ_O  = 1'b0;
    assign O_IRQ_OE = irq_low;

    //**************************************************************************
    // read port
    //**************************************************************************

    // counter bytes show the preset while disabled, the live count otherwise
    wire [15:0] cnt_view = timer_enable_bit ? count : preset;

    wire [7:0] ext_rd  = {3'h0, timer_enable_bit, 1'b0, source_sel};
    wire [7:0] flag_rd = {3'h0, timer_expiry_flag, 4'h0};
    wire [7:0] ctrl_rd = {1'b0, global_stop, 1'b0, timer_irq_enable, 1'b0,
                          timer_stop_bit, backup_select_bit, backup_gating_enable};

    // unmapped addresses read zero
    wire [7:0] rd_mux = (I_ADDR == `RTCWT_ADDR_CNT_LO) ? cnt_view[7:0]  :
                        (I_ADDR == `RTCWT_ADDR_CNT_HI) ? cnt_view[15:8] :
                        (I_ADDR == `RTCWT_ADDR_EXT)    ? ext_rd         :
                        (I_ADDR == `RTCWT_ADDR_FLAG)   ? flag_rd        :
                        (I_ADDR == `RTCWT_ADDR_CTRL)   ? ctrl_rd        : 8'h00;

    // read data stands for one cycle only, zero otherwise
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            O_RDATA <= 8'h00;
        else
            O_RDATA <= I_RD ? rd_mux : 8'h00;
    end

endmodule : rtcwt_top

`default_nettype wire

// file: bench/rtcwt_monitor.sv
// port checker of the wakeup countdown timer
`timescale 1ns/1ps
`default_nettype none

module rtcwt_monitor
#(
    parameter logic [17:0] RTN_SLOW_CYC = 18'h14,
    parameter logic [17:0] RTN_FAST_CYC = 18'h8
)
(
    // clock, reset and register port
    input wire logic       I_CLK,
    input wire logic       I_NRST,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic       I_WR,
    input wire logic       I_RD,
    input wire logic [7:0] O_RDATA,
    // pins
    input wire logic       I_SCL,
    input wire logic       I_VBAT_MODE,
    input wire logic       O_IRQ_O,
    input wire logic       O_IRQ_OE
);
    logic [15:0] pre;     // preset as last written
    logic [7:0]  ext;     // enable and source as last written
    logic [7:0]  ctl;     // control byte as last written
    logic [17:0] low_cnt; // cycles the pin has been pulled low so far
    wire         tie_off = I_WR && I_ADDR == 8'h1e && !I_WDATA[4];
    wire  [17:0] rtn     = (ext[2:0] == 3'h0) ? RTN_FAST_CYC : RTN_SLOW_CYC;

    // shadows follow host writes, so no design internals are needed
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            pre     <= 16'h0000;
            ext     <= 8'h00;
            ctl     <= 8'h00;
            low_cnt <= 18'h0;
        end
        else
        begin
            if (I_WR && I_ADDR == 8'h1a)
                pre[7:0] <= I_WDATA;
            if (I_WR && I_ADDR == 8'h1b)
                pre[15:8] <= I_WDATA;
            if (I_WR && I_ADDR == 8'h1c)
                ext <= I_WDATA;
            if (I_WR && I_ADDR == 8'h1e)
                ctl <= I_WDATA;
            low_cnt <= O_IRQ_OE ? low_cnt + 18'h1 : 18'h0;
        end
    end

    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);

    drive_low_a: assert property (O_IRQ_O == 1'b0)
        else $error("open drain drive value is not low");
    rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
        else $error("read data outside the answer cycle");
    preset_lo_a: assert property (I_RD && I_ADDR == 8'h1a && !ext[4] |=> O_RDATA == pre[7:0])
        else $error("low count byte differs from preset");
    preset_hi_a: assert property (I_RD && I_ADDR == 8'h1b && !ext[4] |=> O_RDATA == pre[15:8])
        else $error("high count byte differs from preset");
    irq_needs_tie_a: assert property ($rose(O_IRQ_OE) |-> $past(ctl[4]))
        else $error("pin pulled low with irq enable off");
    irq_needs_en_a: assert property ($rose(O_IRQ_OE) |-> $past(ext[4]))
        else $error("expiry while timer disabled");
    stop_freeze_a: assert property ($rose(O_IRQ_OE) |-> !$past(ctl[2] && !ctl[0]))
        else $error("expiry while stop bit freezes count");
    gstop_freeze_a: assert property ($rose(O_IRQ_OE) |-> !$past(ctl[6] && ext[2:0] != 3'h0))
        else $error("expiry of slow source under global stop");
    hold_min_a: assert property ($fell(O_IRQ_OE) |-> $past(tie_off) || low_cnt >= rtn)
        else $error("pin released early");
    tie_cut_a: assert property (tie_off && O_IRQ_OE |=> !O_IRQ_OE)
        else $error("pin kept low after irq enable cleared");
endmodule : rtcwt_monitor

bind rtcwt_top rtcwt_monitor #(
    .RTN_SLOW_CYC(RTN_SLOW_CYC),
    .RTN_FAST_CYC(RTN_FAST_CYC)
) i_monitor (.*);
`default_nettype wire

// file: bench/rtcwt_scl_host.sv
// host side of the serial bus: runs the clock line through one frame
`timescale 1ns/1ps
`default_nettype none

module rtcwt_scl_host
(
    // frame request and pacing
    input  wire logic i_go,
    input  wire logic i_slow,
    // serial clock line, pulled up and still between frames
    output var  logic o_scl
);
    initial o_scl = 1'b1;

    // eight data clocks, then the acknowledge clock
    always @(posedge i_go)
    begin
        #7;
        repeat (9)
        begin
            #(i_slow ? 960 : 160) o_scl = 1'b0;
            #160 o_scl = 1'b1;
        end
    end
endmodule : rtcwt_scl_host
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench of the wakeup countdown timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        num_checks++; \
        if ((got) !== (ex)) \
        begin \
            bad_count++; \
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
        end \
    end

module testbench;
    logic       clk, nrst, we, re, scl, vbat, go, slow, oe, od;
    logic [7:0] addr, wdata, rdata;
    int         bad_count, num_checks;
    int         ncyc = 0;

    // fast prescaler: one 4096 Hz tick every ten clocks
    rtcwt_top #(
        .CLK_HZ(40960),
        .RTN_SLOW_CYC(18'h14),
        .RTN_FAST_CYC(18'h8)
    ) i_dut (
        .I_CLK(clk),
        .I_NRST(nrst),
        .I_ADDR(addr),
        .I_WDATA(wdata),
        .I_WR(we),
        .I_RD(re),
        .O_RDATA(rdata),
        .I_SCL(scl),
        .I_VBAT_MODE(vbat),
        .O_IRQ_O(od),
        .O_IRQ_OE(oe)
    );
    rtcwt_scl_host i_host (.i_go(go), .i_slow(slow), .o_scl(scl));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) ncyc <= ncyc + 1;

    task automatic close_out;
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // bus accesses; a spare cycle between strobes keeps each driver single
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [7:0] ex);
        logic [7:0] d;
        rd(a, d);
        `CHK($sformatf("reg %h", a), ex, d)
    endtask : rchk
    // live count is not latched across bytes; compare with care
    task automatic cnt(output logic [15:0] v);
        rd(8'h1a, v[7:0]);
        rd(8'h1b, v[15:8]);
    endtask : cnt
    task automatic frame;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (slow ? 260 : 80) @(posedge clk);
    endtask : frame
    // waits for the next pull-down of the pin, bounded
    task automatic rise(output int t);
        int n = 0;
        while (oe !== 1'b0 && n < 3000) begin @(negedge clk); n++; end
        while (oe !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
        `CHK("irq rise", 1'b1, oe)
        t = ncyc;
        @(posedge clk);
    endtask : rise

    task automatic t_reset;
        for (int a = 8'h1a; a <= 8'h1e; a++)
            rchk(8'(a), 8'h00);
        rchk(8'h55, 8'h00);
        `CHK("irq idle", 1'b0, oe)
        `CHK("irq drive", 1'b0, od)
    endtask : t_reset
    task automatic t_select;
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h1c, 8'(c));
            rchk(8'h1c, 8'(c));
        end
    endtask : t_select
    task automatic t_start;
        logic [15:0] v;
        wr(8'h1c, 8'h00);
        wr(8'h1a, 8'h34);
        wr(8'h1b, 8'h12);
        rchk(8'h1a, 8'h34);
        rchk(8'h1b, 8'h12);
        wr(8'h1c, 8'h10);
        repeat (40) @(posedge clk);
        cnt(v);
        `CHK("armed", 16'h1234, v)
        frame;
        cnt(v);
        `CHK("started", 1'b1, v < 16'h1234)
        wr(8'h1c, 8'h00);
        rchk(8'h1a, 8'h34);
        wr(8'h1c, 8'h10);
        cnt(v);
        `CHK("reload", 16'h1234, v)
    endtask : t_start
    task automatic t_stop;
        logic [15:0] v1, v2;
        frame;
        repeat (400) @(posedge clk);
        wr(8'h1e, 8'h04);
        cnt(v1);
        repeat (200) @(posedge clk);
        cnt(v2);
        `CHK("frozen", v1, v2)
        wr(8'h1e, 8'h00);
        repeat (200) @(posedge clk);
        cnt(v2);
        `CHK("resumed", 1'b1, v2 < v1)
        wr(8'h1e, 8'h05);
        cnt(v1);
        repeat (200) @(posedge clk);
        cnt(v2);
        `CHK("stop ignored", 1'b1, v2 < v1)
        wr(8'h1e, 8'h07);
        cnt(v1);
        repeat (200) @(posedge clk);
        cnt(v2);
        `CHK("main gated", v1, v2)
        vbat <= 1'b1;
        repeat (200) @(posedge clk);
        cnt(v2);
        `CHK("battery counts", 1'b1, v2 < v1)
        vbat <= 1'b0;
        wr(8'h1e, 8'h00);
    endtask : t_stop
    task automatic t_gstop;
        logic [15:0] v1, v2;
        wr(8'h1c, 8'h00);
        wr(8'h1c, 8'h11);
        slow <= 1'b1;
        frame;
        slow <= 1'b0;
        wr(8'h1e, 8'h40);
        cnt(v1);
        repeat (1500) @(posedge clk);
        cnt(v2);
        `CHK("global stop", v1, v2)
        wr(8'h1e, 8'h00);
    endtask : t_gstop
    task automatic t_irq;
        int t1, t2;
        wr(8'h1c, 8'h00);
        wr(8'h1a, 8'h03);
        wr(8'h1b, 8'h00);
        wr(8'h1e, 8'h10);
        wr(8'h1c, 8'h10);
        frame;
        rise(t1);
        rchk(8'h1d, 8'h10);
        wr(8'h1d, 8'h10);
        rchk(8'h1d, 8'h10);
        wr(8'h1d, 8'h00);
        rchk(8'h1d, 8'h00);
        rise(t2);
        `CHK("fast period", 30, t2 - t1)
        rise(t1);
        wr(8'h1c, 8'h00);
        @(negedge clk);
        `CHK("kept low", 1'b1, oe)
        @(posedge clk);
        wr(8'h1c, 8'h10);
        frame;
        rise(t1);
        wr(8'h1e, 8'h00);
        @(negedge clk);
        `CHK("irq off", 1'b0, oe)
        @(posedge clk);
        wr(8'h1d, 8'h00);
        // lands inside the low window an unmasked third expiry would open
        repeat (88) @(negedge clk);
        `CHK("masked", 1'b0, oe)
        @(posedge clk);
        rchk(8'h1d, 8'h10);
        wr(8'h1c, 8'h00);
        wr(8'h1a, 8'h01);
        wr(8'h1e, 8'h10);
        wr(8'h1c, 8'h11);
        frame;
        rise(t1);
        rise(t2);
        `CHK("slow period", 640, t2 - t1)
    endtask : t_irq

    initial
    begin
        nrst = 1'b0;
        we = 1'b0;
        re = 1'b0;
        go = 1'b0;
        slow = 1'b0;
        vbat = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        bad_count = 0;
        num_checks = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset;
        t_select;
        t_start;
        t_stop;
        t_gstop;
        t_irq;
        close_out;
    end

    // watchdog: about twenty times the expected run
    initial
    begin
        #4000000;
        bad_count++;
        close_out;
    end
endmodule : testbench
`default_nettype wire
